// ---- src/pwm_pkg.sv ----
// Pulse width modulator package: register map, fields, reset values, states.
// Assumes a 32-bit classic Wishbone slave port and one 200 MHz clock.
package pwm_pkg;
  localparam int          PWM_NUM         = 4;
  localparam int          PWM_AW          = 8;
  localparam int          PWM_IDX_W       = 2;
  // Per-instance window of 16 bytes, instance index in address bits 5:4
  localparam int          PWM_INST_LSB    = 4;
  localparam logic [3:0]  PWM_OFS_CFG     = 4'h0;
  localparam logic [3:0]  PWM_OFS_PER     = 4'h4;
  localparam logic [3:0]  PWM_OFS_PH1     = 4'h8;
  localparam logic [3:0]  PWM_OFS_RPT     = 4'hc;
  localparam logic [7:0]  PWM_ADR_STAT    = 8'h40;
  localparam logic [7:0]  PWM_ADR_MASK    = 8'h44;
  localparam logic [7:0]  PWM_ADR_START   = 8'h48;
  // Config register fields
  localparam int          CFG_EN          = 0;
  localparam int          CFG_ONESHOT     = 1;
  localparam int          CFG_IDLE_LVL    = 2;
  localparam int          CFG_PH1_LVL     = 3;
  localparam int          CFG_TRIG_FALL   = 4;
  localparam int          CFG_TRIG_FSYNC  = 5;
  localparam int          CFG_W           = 6;
  localparam logic [5:0]  CFG_RST         = 6'h00;
  localparam logic [31:0] PER_RST         = 32'h0000_0000;
  localparam logic [31:0] PH1_RST         = 32'h0000_0000;
  localparam logic [7:0]  RPT_RST         = 8'h00;
  // Status bits per instance: period end, run done
  localparam int          EVT_W           = 2;
  localparam int          EVT_PERIOD      = 0;
  localparam int          EVT_DONE        = 1;
  localparam logic [31:0] CNT_ONE         = 32'h0000_0001;
  localparam logic [7:0]  RPT_ONE         = 8'h01;
  typedef enum logic [2:0] {
    PWM_IDLE = 3'b001,
    PWM_RUN  = 3'b010,
    PWM_STOP = 3'b100
  } pwm_state_e;
endpackage

// ---- src/pwm_chan.sv ----
// One pulse width modulator channel: period counter and first-phase compare.
// Assumes synchronous inputs; the trigger is already synchronised.
module pwm_chan
  import pwm_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [CFG_W-1:0]  cfg_i,
  input  wire logic [31:0]       per_buf_i,
  input  wire logic [31:0]       ph1_buf_i,
  input  wire logic [7:0]        rpt_i,
  input  wire logic              sw_start_i,
  input  wire logic              trig_i,
  output logic                   pin_o,
  output logic                   period_evt_o,
  output logic                   done_evt_o,
  output logic                   busy_o
);
  pwm_state_e  state;
  pwm_state_e  next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [31:0] per;
  logic [31:0] next_per;
  logic [31:0] ph1;
  logic [31:0] next_ph1;
  logic [7:0]  rpt;
  logic [7:0]  next_rpt;
  logic        trig_q;
  logic        next_pin;
  logic        next_pevt;
  logic        next_devt;
  logic        edge_hit;
  logic        last_cnt;

  // Selected edge of the trigger source
  assign edge_hit = cfg_i[CFG_TRIG_FALL] ? (trig_q & ~trig_i) : (~trig_q & trig_i);
  assign last_cnt = (cnt >= per - CNT_ONE) || (per == '0);

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_per   = per;
    next_ph1   = ph1;
    next_rpt   = rpt;
    next_pevt  = 1'b0;
    next_devt  = 1'b0;
    next_pin   = cfg_i[CFG_IDLE_LVL];
    case (state)
      PWM_IDLE:
      begin
        if (cfg_i[CFG_EN] && (!cfg_i[CFG_ONESHOT] || edge_hit || sw_start_i))
        begin
          next_state = PWM_RUN;
          next_cnt   = '0;
          next_per   = per_buf_i;
          next_ph1   = ph1_buf_i;
          next_rpt   = rpt_i;
        end
      end
      PWM_RUN:
      begin
        // First phase while count below duration, opposite level after
        next_pin = (cnt < ph1) ? cfg_i[CFG_PH1_LVL] : ~cfg_i[CFG_PH1_LVL];
        next_cnt = cnt + CNT_ONE;
        if (!cfg_i[CFG_EN])
        begin
          next_state = PWM_IDLE;
        end
        else if (last_cnt)
        begin
          next_pevt = 1'b1;
          next_cnt  = '0;
          next_per  = per_buf_i;
          next_ph1  = ph1_buf_i;
          if (cfg_i[CFG_ONESHOT])
          begin
            if (rpt == '0)
            begin
              next_state = PWM_STOP;
              next_devt  = 1'b1;
            end
            else
            begin
              next_rpt = rpt - RPT_ONE;
            end
          end
        end
      end
      PWM_STOP:
      begin
        // Back to idle level, rearm only on a fresh trigger edge or a software start pulse
        next_state = PWM_IDLE;
      end
      default:
      begin
        next_state = PWM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state        <= PWM_IDLE;
      cnt          <= '0;
      per          <= PER_RST;
      ph1          <= PH1_RST;
      rpt          <= RPT_RST;
      trig_q       <= 1'b0;
      pin_o        <= 1'b0;
      period_evt_o <= 1'b0;
      done_evt_o   <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      cnt          <= next_cnt;
      per          <= next_per;
      ph1          <= next_ph1;
      rpt          <= next_rpt;
      trig_q       <= trig_i;
      pin_o        <= next_pin;
      period_evt_o <= next_pevt;
      done_evt_o   <= next_devt;
    end
  end

  assign busy_o = (state == PWM_RUN);
endmodule

// ---- src/pwm_top.sv ----
// Four independent pulse width modulators behind a classic Wishbone slave.
// Assumes one 200 MHz clock, synchronous reset; trigger pins are asynchronous.
//
// Chosen here: the address map and the Wishbone interface to the registers.
module pwm_top
  import pwm_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [PWM_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [PWM_NUM-1:0]  hw_event_i,
  input  wire logic                sensor_frame_sync_i,
  output logic      [PWM_NUM-1:0]  modulator_output_pin_o,
  output logic      [PWM_NUM-1:0]  dma_sync_o,
  output logic                     irq_o
);
  localparam int STAT_W = PWM_NUM * EVT_W;

  // Register state
  logic [CFG_W-1:0]  cfg      [PWM_NUM];
  logic [CFG_W-1:0]  next_cfg [PWM_NUM];
  logic [31:0]       per_buf  [PWM_NUM];
  logic [31:0]       next_per_buf [PWM_NUM];
  logic [31:0]       ph1_buf  [PWM_NUM];
  logic [31:0]       next_ph1_buf [PWM_NUM];
  logic [7:0]        rpt      [PWM_NUM];
  logic [7:0]        next_rpt [PWM_NUM];
  logic [STAT_W-1:0] stat;
  logic [STAT_W-1:0] next_stat;
  logic [STAT_W-1:0] mask;
  logic [STAT_W-1:0] next_mask;
  logic [PWM_NUM-1:0] start_pls;
  logic [PWM_NUM-1:0] next_start_pls;
  logic [31:0]       next_dat;
  logic              next_ack;

  // Synchronisers
  logic [PWM_NUM-1:0] evt_s1;
  logic [PWM_NUM-1:0] evt_s2;
  logic              fs_s1;
  logic              fs_s2;

  // Channel results
  logic [PWM_NUM-1:0] trig;
  logic [PWM_NUM-1:0] per_evt;
  logic [PWM_NUM-1:0] done_evt;
  logic [PWM_NUM-1:0] busy;
  logic [STAT_W-1:0]  evt_vec;

  logic              req;
  logic              wr;
  logic              rd;
  logic [PWM_IDX_W-1:0] inst;
  logic [3:0]        ofs;
  logic              in_chan;

  // Byte-lane merge of a write into a 32-bit value
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = req & wb_we_i;
  assign rd      = req & ~wb_we_i;
  assign inst    = wb_adr_i[PWM_INST_LSB +: PWM_IDX_W];
  assign ofs     = wb_adr_i[PWM_INST_LSB-1:0];
  assign in_chan = (wb_adr_i < PWM_ADR_STAT);

  // Channel i uses its own pin or the frame sync as trigger
  always_comb
  begin
    for (int i = 0; i < PWM_NUM; i++)
    begin
      trig[i] = cfg[i][CFG_TRIG_FSYNC] ? fs_s2 : evt_s2[i];
      evt_vec[i*EVT_W + EVT_PERIOD] = per_evt[i];
      evt_vec[i*EVT_W + EVT_DONE]   = done_evt[i];
    end
  end

  always_comb
  begin
    next_ack       = req;
    next_dat       = '0;
    next_start_pls = '0;
    next_mask      = mask;
    next_stat      = stat;
    for (int i = 0; i < PWM_NUM; i++)
    begin
      next_cfg[i]     = cfg[i];
      next_per_buf[i] = per_buf[i];
      next_ph1_buf[i] = ph1_buf[i];
      next_rpt[i]     = rpt[i];
    end
    if (wr && in_chan)
    begin
      case (ofs)
        PWM_OFS_CFG:
        begin
          if (wb_sel_i[0])
          begin
            next_cfg[inst] = wb_dat_i[CFG_W-1:0];
          end
        end
        PWM_OFS_PER: next_per_buf[inst] = lane_merge(per_buf[inst], wb_dat_i, wb_sel_i);
        PWM_OFS_PH1: next_ph1_buf[inst] = lane_merge(ph1_buf[inst], wb_dat_i, wb_sel_i);
        PWM_OFS_RPT:
        begin
          if (wb_sel_i[0])
          begin
            next_rpt[inst] = wb_dat_i[7:0];
          end
        end
        default:
        begin
          next_ack = req;
        end
      endcase
    end
    else if (wr && wb_adr_i == PWM_ADR_MASK && wb_sel_i[0])
    begin
      next_mask = wb_dat_i[STAT_W-1:0];
    end
    else if (wr && wb_adr_i == PWM_ADR_START && wb_sel_i[0])
    begin
      next_start_pls = wb_dat_i[PWM_NUM-1:0];
    end
    if (rd && in_chan)
    begin
      case (ofs)
        PWM_OFS_CFG: next_dat = {{(32-CFG_W-1){1'b0}}, busy[inst], cfg[inst]};
        PWM_OFS_PER: next_dat = per_buf[inst];
        PWM_OFS_PH1: next_dat = ph1_buf[inst];
        PWM_OFS_RPT: next_dat = {24'h00_0000, rpt[inst]};
        default:     next_dat = '0;
      endcase
    end
    else if (rd && wb_adr_i == PWM_ADR_STAT)
    begin
      next_dat  = {{(32-STAT_W){1'b0}}, stat};
      next_stat = '0;
    end
    else if (rd && wb_adr_i == PWM_ADR_MASK)
    begin
      next_dat = {{(32-STAT_W){1'b0}}, mask};
    end
    // New events win over the read clear
    next_stat = next_stat | evt_vec;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < PWM_NUM; i++)
      begin
        cfg[i]     <= CFG_RST;
        per_buf[i] <= PER_RST;
        ph1_buf[i] <= PH1_RST;
        rpt[i]     <= RPT_RST;
      end
      stat      <= '0;
      mask      <= '0;
      start_pls <= '0;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= '0;
      evt_s1    <= '0;
      evt_s2    <= '0;
      fs_s1     <= 1'b0;
      fs_s2     <= 1'b0;
      irq_o     <= 1'b0;
      dma_sync_o <= '0;
    end
    else
    begin
      for (int i = 0; i < PWM_NUM; i++)
      begin
        cfg[i]     <= next_cfg[i];
        per_buf[i] <= next_per_buf[i];
        ph1_buf[i] <= next_ph1_buf[i];
        rpt[i]     <= next_rpt[i];
      end
      stat      <= next_stat;
      mask      <= next_mask;
      start_pls <= next_start_pls;
      wb_ack_o  <= next_ack;
      wb_dat_o  <= next_dat;
      evt_s1    <= hw_event_i;
      evt_s2    <= evt_s1;
      fs_s1     <= sensor_frame_sync_i;
      fs_s2     <= fs_s1;
      irq_o     <= |(next_stat & mask);
      dma_sync_o <= per_evt | done_evt;
    end
  end

  // Four independent channels
  for (genvar g = 0; g < PWM_NUM; g++)
  begin : g_chan
    pwm_chan u_chan (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .cfg_i        (cfg[g]),
      .per_buf_i    (per_buf[g]),
      .ph1_buf_i    (ph1_buf[g]),
      .rpt_i        (rpt[g]),
      .sw_start_i   (start_pls[g]),
      .trig_i       (trig[g]),
      .pin_o        (modulator_output_pin_o[g]),
      .period_evt_o (per_evt[g]),
      .done_evt_o   (done_evt[g]),
      .busy_o       (busy[g])
    );
  end
endmodule

// ---- dv/pwm_load.sv ----
// Load model on the four modulator pins: counts rising edges and high runs.
// Assumes pins are registered on clk_i; clr_i zeroes the edge counts.
module pwm_load
(
  input  wire logic        clk_i,
  input  wire logic        clr_i,
  input  wire logic [3:0]  pin_i,
  output logic      [7:0]  rises_o [4],
  output logic      [7:0]  hi_o [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] last;
  logic [7:0] run [4];
  always_ff @(posedge clk_i)
  begin
    last <= pin_i;
    for (int n = 0; n < 4; n++)
    begin
      if (clr_i)
        rises_o[n] <= 8'h00;
      else if (pin_i[n] && !last[n])
        rises_o[n] <= rises_o[n] + 8'h01;
      run[n] <= pin_i[n] ? run[n] + 8'h01 : 8'h00;
      if (!pin_i[n] && last[n])
        hi_o[n] <= run[n];
    end
  end
endmodule

// ---- dv/pwm_props.sv ----
// Checker on the pins of the modulator top: bus answers, reset, interrupt.
// Assumes one clock and synchronous active-high reset.
module pwm_props
  import pwm_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [PWM_AW-1:0]   wb_adr_i,
  input  wire logic [31:0]         wb_dat_o,
  input  wire logic                wb_ack_o,
  input  wire logic [PWM_NUM-1:0]  dma_sync_o,
  input  wire logic [PWM_NUM-1:0]  modulator_output_pin_o,
  input  wire logic                irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_answer_a: assert property (req |=> wb_ack_o) else $error("request not answered");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
  hole_read_a: assert property (req && !wb_we_i && wb_adr_i[7] |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property ($past(rst_i) |-> !wb_ack_o && !irq_o
    && dma_sync_o == 4'h0 && modulator_output_pin_o == 4'h0)
    else $error("outputs not idle after reset");
  irq_cause_a: assert property ($rose(irq_o) |-> (|dma_sync_o)
    || $past(wb_ack_o && wb_we_i)) else $error("irq without cause");
  irq_clear_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == PWM_ADR_STAT
    && dma_sync_o == 4'h0 ##1 (dma_sync_o == 4'h0)[*3] |-> !irq_o) else $error("irq kept");
  cover property ($rose(irq_o));
  cover property (dma_sync_o[1]);
  cover property ($rose(modulator_output_pin_o[0]));
endmodule
bind pwm_top pwm_props i_pwm_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .dma_sync_o(dma_sync_o),
  .modulator_output_pin_o(modulator_output_pin_o), .irq_o(irq_o));

// ---- dv/tb.sv ----
// Self-checking bench for the four-channel modulator over classic Wishbone.
// Assumes pwm_top, pwm_load and the bound checker are compiled before it.
module tb;
  import pwm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} pwm_row_s;
  localparam pwm_row_s ROWS [5] = '{'{8'h14, 32'hdeadbeef, 32'hdeadbeef},
    '{8'h28, 32'hffffffff, 32'hffffffff}, '{8'h3c, 32'h000001ff, 32'h000000ff},
    '{8'h10, 32'h0000007e, 32'h0000003e}, '{8'h80, 32'h00001234, 32'h00000000}};
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b1, fsync = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, wb_dat_o;
  logic [3:0] sel = 4'hf, hw_ev = 4'h0, pins, dma;
  logic wb_ack_o, irq_o;
  logic [7:0] rises [4], hi [4];
  int mismatches = 0, compares = 0;
  logic [7:0] dma_seen = 8'h00;
  always #2.5 clk_i = ~clk_i;
  // Counts sync pulses of channel 3 since the last clear
  always @(posedge clk_i)
  begin
    if (clr)
      dma_seen <= 8'h00;
    else if (dma[3])
      dma_seen <= dma_seen + 8'h01;
  end
  pwm_top i_pwm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .hw_event_i(hw_ev), .sensor_frame_sync_i(fsync), .modulator_output_pin_o(pins),
    .dma_sync_o(dma), .irq_o(irq_o));
  pwm_load i_pwm_load (.clk_i(clk_i), .clr_i(clr), .pin_i(pins), .rises_o(rises), .hi_o(hi));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic setup(input logic [7:0] b, input logic [31:0] p, input logic [31:0] f,
                       input logic [31:0] cfg);
    wb(1'b1, b + 8'h4, p);
    wb(1'b1, b + 8'h8, f);
    wb(1'b1, b + 8'hc, 32'h1);
    wb(1'b1, b, cfg);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ROWS[i])
    begin
      wb(1'b1, ROWS[i].a, ROWS[i].d);
      wb(1'b0, ROWS[i].a, 32'h0);
      chk(q, ROWS[i].e);
    end
    $display("register table done");
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    chk({28'h0, pins}, 32'h0);
    setup(8'h00, 32'h8, 32'h3, 32'h09);
    repeat (40) @(posedge clk_i);
    chk({24'h0, hi[0]}, 32'h3);
    wb(1'b1, 8'h08, 32'h5);
    repeat (40) @(posedge clk_i);
    chk({24'h0, hi[0]}, 32'h5);
    wb(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge clk_i);
    chk({28'h0, pins}, 32'h0);
    wb(1'b0, PWM_ADR_STAT, 32'h0);
    chk(q, 32'h1);
    $display("continuous done");
    wb(1'b1, PWM_ADR_MASK, 32'h0c);
    setup(8'h10, 32'h4, 32'h2, 32'h0b);
    wb(1'b1, 8'h1c, 32'h2);
    wb(1'b1, PWM_ADR_START, 32'h2);
    repeat (60) @(posedge clk_i);
    chk({24'h0, rises[1]}, 32'h3);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b0, PWM_ADR_STAT, 32'h0);
    chk(q, 32'h0c);
    repeat (30) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    chk({24'h0, rises[1]}, 32'h3);
    $display("one-shot done");
    setup(8'h20, 32'h4, 32'h2, 32'h1b);
    hw_ev[2] <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk({24'h0, rises[2]}, 32'h0);
    hw_ev[2] <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk({24'h0, rises[2]}, 32'h2);
    setup(8'h30, 32'h4, 32'h2, 32'h2b);
    fsync <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk({24'h0, rises[3]}, 32'h2);
    chk({24'h0, rises[2]}, 32'h0);
    chk({24'h0, dma_seen}, 32'h2);
    $display("triggers done");
    wb(1'b1, 8'h00, 32'h04);
    repeat (3) @(posedge clk_i);
    chk({28'h0, pins}, 32'h1);
    $display("idle level done");
    tally_and_finish();
  end
endmodule
